// file: core/hdlc_dpll_and_bus_access.sv
// Recovery loop, bus access and collision unit of one serial channel
`timescale 1ns/1ps
`include "hdlc_dpll_regs.svh"

module hdlc_dpll_and_bus_access (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire hdlc_dpll_pkg::word_t hwdata,
	input wire logic hready,
	output logic hreadyout,
	output hdlc_dpll_pkg::word_t hrdata,
	output logic hresp,
	// Serial pins
	input wire logic rx_data_pin,
	input wire logic collision_data_input_a,
	input wire logic tx_clock_pin,
	output logic transmit_data_out_a,
	output logic rts_n
);
	import hdlc_dpll_pkg::*;

	function automatic logic mode_is(input logic [2:0] m, input logic [2:0] a,
		input logic [2:0] b);
		mode_is = (m == a) || (m == b);
	endfunction : mode_is

	function automatic logic in_range(input logic [3:0] v, input logic [3:0] lo,
		input logic [3:0] hi);
		in_range = (v >= lo) && (v <= hi);
	endfunction : in_range

	// Pin synchronisers: rx, collision feedback, external transmit clock
	logic [2:0] pin_meta;
	logic [2:0] pin_sync;
	logic rx_prev;
	logic txclk_prev;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pin_meta <= 3'h7;
			pin_sync <= 3'h7;
			rx_prev <= 1'b1;
			txclk_prev <= 1'b1;
		end else begin
			pin_meta <= {rx_data_pin, collision_data_input_a, tx_clock_pin};
			pin_sync <= pin_meta;
			rx_prev <= pin_sync[2];
			txclk_prev <= pin_sync[0];
		end
	end
	logic rx_line;
	logic bus_line;
	assign rx_line = pin_sync[2];
	assign bus_line = pin_sync[1];

	// Register file
	cfg_s cfg, next_cfg;
	logic [15:0] baud_div, next_baud_div;
	logic [7:0] tx_byte, next_tx_byte;
	logic tx_eof, next_tx_eof;
	logic tx_pending, next_tx_pending;
	logic coll_flag, next_coll_flag;
	logic wr_pend, next_wr_pend;
	logic [7:0] wr_addr, next_wr_addr;
	word_t next_hrdata;
	logic tx_take;
	logic coll_event;
	logic bus_idle;
	logic own_busy, next_own_busy;
	logic low_prio, next_low_prio;
	logic [7:0] rx_byte, next_rx_byte;
	logic [7:0] rx_count, next_rx_count;
	logic accept;

	assign accept = hsel && hready && htrans[1];

	always_comb begin
		next_cfg = cfg;
		next_baud_div = baud_div;
		next_tx_byte = tx_byte;
		next_tx_eof = tx_eof;
		next_tx_pending = tx_pending;
		next_coll_flag = coll_flag;
		next_wr_pend = accept && hwrite;
		next_wr_addr = haddr[7:0];
		next_hrdata = '0;
		if (accept && !hwrite) begin
			case (haddr[7:0])
				`CHANNEL_CONFIG_ONE_OFS: next_hrdata = {23'h0, cfg};
				`BAUD_DIVISOR_OFS: next_hrdata = {16'h0, baud_div};
				`TX_DATA_OFS: next_hrdata = {23'h0, tx_eof, tx_byte};
				`LINE_STATUS_OFS: next_hrdata = {27'h0, coll_flag, tx_pending,
					low_prio, own_busy, bus_idle};
				`RX_DATA_OFS: next_hrdata = {16'h0, rx_count, rx_byte};
				default: next_hrdata = '0;
			endcase
		end
		if (wr_pend) begin
			case (wr_addr)
				`CHANNEL_CONFIG_ONE_OFS:
					next_cfg = cfg_s'(hwdata[`CFG_WIDTH-1:0]); // R17
				`BAUD_DIVISOR_OFS: next_baud_div = hwdata[15:0];
				`TX_DATA_OFS: begin
					// A byte written while one is pending is dropped
					if (!tx_pending) begin
						next_tx_byte = hwdata[7:0];
						next_tx_eof = hwdata[`TXD_EOF_BIT];
						next_tx_pending = 1'b1;
					end
				end
				`LINE_STATUS_OFS: begin
					if (hwdata[`ST_COLL_BIT])
						next_coll_flag = 1'b0;
				end
				default: ;
			endcase
		end
		if (tx_take)
			next_tx_pending = 1'b0;
		// Set after clear so a collision in the clearing cycle survives
		if (coll_event)
			next_coll_flag = 1'b1;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cfg <= cfg_s'(`CFG_RESET);
			baud_div <= `BAUD_RESET;
			tx_byte <= 8'h00;
			tx_eof <= 1'b0;
			tx_pending <= 1'b0;
			coll_flag <= 1'b0;
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
			hrdata <= '0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			cfg <= next_cfg;
			baud_div <= next_baud_div;
			tx_byte <= next_tx_byte;
			tx_eof <= next_tx_eof;
			tx_pending <= next_tx_pending;
			coll_flag <= next_coll_flag;
			wr_pend <= next_wr_pend;
			wr_addr <= next_wr_addr;
			hrdata <= next_hrdata;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// Baud generator and recovery loop
	logic [15:0] baud_cnt, next_baud_cnt;
	logic [3:0] dpll_cnt, next_dpll_cnt;
	logic [4:0] edge_gap, next_edge_gap;
	logic cell_edge, next_cell_edge;
	logic edge_hold, next_edge_hold;
	logic dpll_rise, next_dpll_rise;
	logic dpll_fall, next_dpll_fall;
	logic [3:0] div16, next_div16;
	logic ref_tick;
	logic edge_now;
	logic [3:0] step;
	logic [4:0] sum;

	assign ref_tick = (baud_cnt == baud_div);
	assign edge_now = edge_hold || (rx_line != rx_prev);

	always_comb begin
		next_baud_cnt = ref_tick ? 16'h0000 : baud_cnt + 16'h0001;
		next_div16 = div16;
		next_edge_hold = edge_now && !ref_tick;
		next_edge_gap = edge_gap;
		next_cell_edge = cell_edge;
		step = 4'h1;
		if (ref_tick && edge_now && edge_gap >= `REF_RATIO) begin
			if (in_range(dpll_cnt, `ADJ_LO, `ADJ_HI))
				step = 4'h0; // R05
			else if (in_range(dpll_cnt, `SHIFT_LO, `SHIFT_HI) && !cell_edge)
				step = `SHIFT_COUNT; // R06
		end
		sum = {1'b0, dpll_cnt} + {1'b0, step};
		next_dpll_cnt = dpll_cnt;
		next_dpll_rise = 1'b0;
		next_dpll_fall = 1'b0;
		if (ref_tick) begin
			next_dpll_cnt = sum[3:0]; // R19
			next_div16 = div16 + 4'h1; // R01
			next_dpll_rise = sum[4];
			next_dpll_fall = (dpll_cnt < 4'h8) && (sum >= `HALF_COUNT); // R03
			if (sum[4])
				next_cell_edge = 1'b0;
			if (edge_now) begin
				// Gap counts ticks since this edge; close edges get no correction
				next_edge_gap = 5'h01; // R04
				next_cell_edge = 1'b1;
			end else if (edge_gap < `REF_RATIO) begin
				next_edge_gap = edge_gap + 5'h01;
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			baud_cnt <= 16'h0000;
			dpll_cnt <= 4'h0; // R20
			edge_gap <= `REF_RATIO;
			cell_edge <= 1'b0;
			edge_hold <= 1'b0;
			dpll_rise <= 1'b0;
			dpll_fall <= 1'b0;
			div16 <= 4'h0;
		end else begin
			baud_cnt <= next_baud_cnt;
			dpll_cnt <= next_dpll_cnt;
			edge_gap <= next_edge_gap;
			cell_edge <= next_cell_edge;
			edge_hold <= next_edge_hold;
			dpll_rise <= next_dpll_rise;
			dpll_fall <= next_dpll_fall;
			div16 <= next_div16;
		end
	end

	// Receive sampling on the recovered falling edge
	logic [7:0] rx_shift, next_rx_shift;
	logic [2:0] rx_bits, next_rx_bits;
	logic rx_level, next_rx_level;
	logic rx_bit;

	always_comb begin
		next_rx_shift = rx_shift;
		next_rx_bits = rx_bits;
		next_rx_level = rx_level;
		next_rx_byte = rx_byte;
		next_rx_count = rx_count;
		rx_bit = (cfg.nrzi && !cfg.bus_mode) ? (rx_line == rx_level) :
			rx_line; // R18
		if (dpll_fall) begin
			next_rx_level = rx_line;
			next_rx_shift = {rx_bit, rx_shift[7:1]}; // R03
			next_rx_bits = rx_bits + 3'h1;
			if (rx_bits == 3'h7) begin
				next_rx_byte = {rx_bit, rx_shift[7:1]};
				next_rx_count = rx_count + 8'h01;
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rx_shift <= 8'h00;
			rx_bits <= 3'h0;
			rx_level <= 1'b1;
			rx_byte <= 8'h00;
			rx_count <= 8'h00;
		end else begin
			rx_shift <= next_rx_shift;
			rx_bits <= next_rx_bits;
			rx_level <= next_rx_level;
			rx_byte <= next_rx_byte;
			rx_count <= next_rx_count;
		end
	end

	// Transmit clock source
	logic tx_rise;
	logic tx_fall;
	always_comb begin
		if (mode_is(cfg.clock_mode, 3'h2, 3'h6) &&
			cfg.transmit_source_select) begin
			tx_rise = ref_tick && (div16 == 4'hf); // R02
			tx_fall = ref_tick && (div16 == 4'h7);
		end else if (mode_is(cfg.clock_mode, 3'h3, 3'h7)) begin
			tx_rise = dpll_rise; // R02
			tx_fall = dpll_fall;
		end else begin
			tx_rise = pin_sync[0] && !txclk_prev;
			tx_fall = !pin_sync[0] && txclk_prev;
		end
	end

	// Bus access and collision unit; clock-mode independent edges
	tx_state_e tx_state, next_tx_state;
	logic [7:0] sh, next_sh;
	logic [7:0] frame_byte, next_frame_byte;
	logic frame_eof, next_frame_eof;
	logic retry, next_retry;
	logic [2:0] bitn, next_bitn;
	logic drv_bit, next_drv_bit;
	logic line, next_line;
	logic next_rts_n;
	logic [3:0] ones, next_ones;
	logic drive_edge;
	logic bus_free;
	logic start;
	logic b;

	// R13 R14
	assign drive_edge = (cfg.collision_timing_field == 2'b11) ? tx_fall :
		tx_rise; // R08
	assign bus_idle = (ones >= `IDLE_ONES) && !own_busy; // R09
	assign bus_free = !cfg.bus_mode ||
		(ones >= (low_prio ? `LOW_PRIO_ONES : `IDLE_ONES)); // R12

	always_comb begin
		next_tx_state = tx_state;
		next_sh = sh;
		next_frame_byte = frame_byte;
		next_frame_eof = frame_eof;
		next_retry = retry;
		next_bitn = bitn;
		next_drv_bit = drv_bit;
		next_line = line;
		next_rts_n = rts_n;
		next_ones = ones;
		next_own_busy = own_busy;
		next_low_prio = low_prio;
		tx_take = 1'b0;
		coll_event = 1'b0;
		start = 1'b0;
		b = 1'b1;
		if (tx_fall) // R09
			next_ones = !bus_line ? 4'h0 : (ones == 4'hf ? ones : ones + 4'h1);
		if (drive_edge) // R15
			next_rts_n = !(!mode_is(cfg.clock_mode, 3'h2, 3'h3) &&
				!cfg.clock_mode[2] | !cfg.clock_mode[1] ? cfg.rts_frame &&
				tx_state == TX_SEND : 1'b0);
		case (tx_state)
			TX_IDLE: begin
				next_line = 1'b1; // R10
				next_own_busy = 1'b0;
				if (drive_edge && (tx_pending || retry) && bus_free) begin
					start = 1'b1;
					if (low_prio)
						next_low_prio = 1'b0; // R12
				end
			end
			TX_SEND: begin
				// In field 11 the check precedes the drive on the same edge
				if (tx_fall && cfg.bus_mode && (bus_line != drv_bit)) begin
					coll_event = 1'b1; // R11
					next_retry = 1'b1;
					next_line = 1'b1;
					next_own_busy = 1'b0;
					next_tx_state = TX_IDLE;
					next_rts_n = 1'b1;
				end else if (drive_edge) begin
					if (bitn != 3'h7) begin
						b = sh[0];
						next_sh = {1'b1, sh[7:1]};
						next_bitn = bitn + 3'h1;
					end else if (!frame_eof && tx_pending) begin
						b = tx_byte[0];
						next_sh = {1'b1, tx_byte[7:1]};
						next_frame_byte = tx_byte;
						next_frame_eof = tx_eof;
						next_bitn = 3'h0;
						tx_take = 1'b1;
					end else begin
						next_line = 1'b1;
						next_own_busy = 1'b0;
						next_tx_state = TX_IDLE;
						if (cfg.bus_mode && frame_eof)
							next_low_prio = 1'b1; // R12
					end
				end
			end
			default: begin
				next_tx_state = TX_IDLE;
				next_line = 1'b1;
			end
		endcase
		if (start) begin
			if (!retry) begin
				next_frame_byte = tx_byte;
				next_frame_eof = tx_eof;
				tx_take = 1'b1;
			end
			b = retry ? frame_byte[0] : tx_byte[0];
			next_sh = {1'b1, retry ? frame_byte[7:1] : tx_byte[7:1]};
			next_retry = 1'b0;
			// Bit 0 goes now; seven more edges before the byte ends
			next_bitn = 3'h0;
			next_tx_state = TX_SEND;
		end
		if (start || (tx_state == TX_SEND && next_tx_state == TX_SEND &&
			drive_edge && !coll_event)) begin
			next_drv_bit = b;
			// R18 R07
			next_line = (cfg.nrzi && !cfg.bus_mode) ? (b ? line : !line) : b;
			if (!b)
				next_own_busy = 1'b1; // R09
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			tx_state <= TX_IDLE;
			sh <= 8'hff;
			frame_byte <= 8'hff;
			frame_eof <= 1'b0;
			retry <= 1'b0;
			bitn <= 3'h0;
			drv_bit <= 1'b1;
			line <= 1'b1; // R20
			rts_n <= 1'b1;
			ones <= 4'h0;
			own_busy <= 1'b0;
			low_prio <= 1'b0; // R20
		end else begin
			tx_state <= next_tx_state;
			sh <= next_sh;
			frame_byte <= next_frame_byte;
			frame_eof <= next_frame_eof;
			retry <= next_retry;
			bitn <= next_bitn;
			drv_bit <= next_drv_bit;
			line <= next_line;
			rts_n <= next_rts_n;
			ones <= next_ones;
			own_busy <= next_own_busy;
			low_prio <= next_low_prio;
		end
	end

	assign transmit_data_out_a = line; // R10
endmodule : hdlc_dpll_and_bus_access

// file: core/hdlc_dpll_regs.svh
// Register map, field positions, reset values and counts of the line front end
//
// Notes on behaviour
// R01: Modes 2,3,6,7 feed the recovery loop from the baud generator at 16x.
// R02: Modes 2,6 with source select: transmit clock baud/16; modes 3,7: loop.
// R03: Loop aligns to data edges; bits sampled mid-cell on recovered fall.
// R04: Two edges within 16 reference ticks are interference; no correction.
// R05: Edge at 20 to 112 degrees moves loop phase by one sixteenth bit.
// R06: Sole edge of a cell at counts 5 to 10 shifts phase by fixed count.
// R07: Bus needs NRZ, wired-OR drivers, bus state fed to collision input.
// R08: Bus access works in every clock mode, including modes 1 and 5.
// R09: Bus idle after eight ones; own frame makes it busy from first zero.
// R10: Transmit output holds one when bus is taken or nothing is pending.
// R11: Sent bit mismatching bus aborts frame at once, sends ones, retries.
// R12: After good frame priority drops: ten ones needed, then eight again.
// R13: Timing field 01: drive on rising transmit edge, check on falling edge.
// R14: Timing field 11: drive on falling edge, check on next falling edge.
// R15: Modes 0,1,4,5: request-to-send marks clean bits, one clock behind data.
// R16: Outside driver enable must AND request-to-send with transmit data.
// R17: A configuration register selects bus mode, else NRZ or NRZI.
// R18: NRZI sends zero as level change, one as unchanged level.
// R19: Loop runs modulo-sixteen counter on reference clock; count gives phase.
// R20: Reset zeroes loop counter, priority normal, transmit output at one.
`ifndef HDLC_DPLL_REGS_SVH
`define HDLC_DPLL_REGS_SVH

`define CHANNEL_CONFIG_ONE_OFS 8'h00
`define BAUD_DIVISOR_OFS 8'h04
`define TX_DATA_OFS 8'h08
`define LINE_STATUS_OFS 8'h0c
`define RX_DATA_OFS 8'h10

`define CFG_WIDTH 9
`define CFG_RESET 9'h000
`define BAUD_RESET 16'h0000
`define TXD_EOF_BIT 8
`define ST_COLL_BIT 4

`define REF_RATIO 5'h10
`define IDLE_ONES 4'h8
`define LOW_PRIO_ONES 4'ha
`define SHIFT_COUNT 4'h8
`define ADJ_LO 4'h1
`define ADJ_HI 4'h4
`define SHIFT_LO 4'h5
`define SHIFT_HI 4'ha
`define HALF_COUNT 5'h08

`endif

// file: core/hdlc_dpll_pkg.sv
// Types shared by the line front end
package hdlc_dpll_pkg;
	typedef logic [31:0] word_t;

	typedef struct packed {
		logic rts_frame;
		logic transmit_source_select;
		logic [1:0] collision_timing_field;
		logic nrzi;
		logic bus_mode;
		logic [2:0] clock_mode;
	} cfg_s;

	typedef enum logic [1:0] {
		TX_IDLE = 2'b01,
		TX_SEND = 2'b10
	} tx_state_e;
endpackage : hdlc_dpll_pkg

// file: verif/front_end_assertions.sv
// Port checker of the line front end, bound to its top module
`timescale 1ns/1ps
module front_end_checker (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// AHB-Lite slave side
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire hdlc_dpll_pkg::word_t hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire hdlc_dpll_pkg::word_t hrdata,
	input wire logic hresp,
	// Serial outputs
	input wire logic transmit_data_out_a,
	input wire logic rts_n
);
	import hdlc_dpll_pkg::*;
	logic req;
	logic cfg_dp;
	logic [8:0] cfg;
	assign req = hsel && hready && htrans[1];
	// Shadow of the config word, updated when the data phase ends
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cfg_dp <= 1'b0;
			cfg <= 9'h000;
		end else begin
			cfg_dp <= req && hwrite && haddr[7:0] == 8'h00;
			if (cfg_dp) begin
				cfg <= hwdata[8:0];
			end
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	sequence rd_at(logic [7:0] a);
		req && !hwrite && haddr[7:0] == a;
	endsequence
	sequence rd_none;
		!(req && !hwrite);
	endsequence
	resp_okay_a: assert property (!hresp)
		else $error("error response seen");
	ready_high_a: assert property (hreadyout)
		else $error("wait state seen");
	rdata_drop_a: assert property (rd_none |=> hrdata == 32'h0)
		else $error("read data left standing");
	unmapped_zero_a: assert property (rd_at(8'h14) |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	// Skip a read that meets a config write in flight
	cfg_back_a: assert property (rd_at(8'h00) ##0 !cfg_dp |=>
		hrdata == {23'h0, cfg})
		else $error("config readback wrong");
	status_width_a: assert property (rd_at(8'h0c) |=> hrdata[31:5] == 27'h0)
		else $error("status upper bits set");
	rts_mode_a: assert property (!rts_n |-> cfg[8] && !cfg[1])
		else $error("request-to-send in wrong mode");
	reset_idle_a: assert property ($fell(reset) |-> transmit_data_out_a && rts_n)
		else $error("line not idle after reset");
endmodule : front_end_checker

bind hdlc_dpll_and_bus_access front_end_checker chk (.clk, .reset, .hsel,
	.haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hrdata, .hresp,
	.transmit_data_out_a, .rts_n);

// file: verif/bus_station_model.sv
// Far station on the shared serial bus, with its modem clock
`timescale 1ns/1ps
module bus_station_model (
	// Clock
	input wire logic clk,
	// Commands from the bench
	input wire logic jam,
	input wire logic [1:0] rx_pattern,
	// Front end pins
	input wire logic transmit_data_out_a,
	input wire logic rts_n,
	output logic collision_data_input_a,
	output logic tx_clock_pin,
	output logic rx_data_pin,
	output logic line_enable
);
	logic [4:0] phase = 5'h00;
	always @(posedge clk) phase <= phase + 5'h01;
	// Modem clock runs free, 32 system clocks a bit
	assign tx_clock_pin = phase[4];
	// A zero from any station wins the bus
	assign collision_data_input_a = transmit_data_out_a & ~jam;
	// Driver enable gated by data so the first bit is right
	assign line_enable = ~rts_n & transmit_data_out_a;
	// Receive line: ones, or a level change every 16 clocks
	assign rx_data_pin = (rx_pattern == 2'h2) ? phase[4] : 1'b1;
endmodule : bus_station_model

// file: verif/tb_hdlc_dpll_and_bus_access.sv
// Self-checking bench of the line front end
`timescale 1ns/1ps
`include "hdlc_dpll_regs.svh"
module tb_hdlc_dpll_and_bus_access;
	import hdlc_dpll_pkg::*;
	typedef struct packed {
		logic [7:0] addr;
		word_t wdata;
		word_t rdata;
	} row_s;
	row_s rows [3] = '{
		'{`BAUD_DIVISOR_OFS, 32'hffff_1234, 32'h0000_1234},
		'{`CHANNEL_CONFIG_ONE_OFS, 32'hffff_fe49, 32'h0000_0049},
		'{8'h14, 32'h0000_00ff, 32'h0000_0000}
	};
	logic clk, reset, hsel, hwrite, jam, hready;
	logic hreadyout, hresp, rx_data_pin, collision_data_input_a;
	logic tx_clock_pin, transmit_data_out_a, rts_n;
	logic [31:0] haddr;
	logic [1:0] htrans, rx_pattern;
	logic [2:0] hsize;
	logic [7:0] bits, rts, c0;
	word_t hwdata, hrdata, rd_val;
	int err_count = 0;
	int n_compared = 0;
	assign hready = hreadyout;
	hdlc_dpll_and_bus_access DUT (.clk, .reset, .hsel, .haddr, .htrans,
		.hwrite, .hsize, .hwdata, .hready, .hreadyout, .hrdata, .hresp,
		.rx_data_pin, .collision_data_input_a, .tx_clock_pin,
		.transmit_data_out_a, .rts_n);
	bus_station_model far (.clk, .jam, .rx_pattern, .transmit_data_out_a,
		.rts_n, .collision_data_input_a, .tx_clock_pin, .rx_data_pin,
		.line_enable());
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic close_out();
		$display("compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : close_out
	task automatic cmp(input word_t got, input word_t want);
		n_compared++;
		if (got !== want) begin
			err_count++;
			$display("mismatch at %0t: got %h want %h", $time, got, want);
		end
	endtask : cmp
	task automatic bus(input logic w, input logic [7:0] a, input word_t d);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= w;
		repeat (2) begin
			do @(posedge clk); while (hready !== 1'b1);
			htrans <= 2'b00;
			hsel <= 1'b0;
			hwdata <= d;
		end
		rd_val = hrdata;
	endtask : bus
	// Waits for the opening zero of a frame, bounded
	task automatic fall();
		int n;
		for (n = 0; n < 3000 && transmit_data_out_a !== 1'b0; n++) begin
			@(posedge clk);
		end
	endtask : fall
	// Samples eight bits at the edge opposite the drive edge
	task automatic sample(input logic on_rise);
		for (int n = 0; n < 8; n++) begin
			if (on_rise) @(posedge tx_clock_pin);
			else @(negedge tx_clock_pin);
			bits[n] = transmit_data_out_a;
			rts[n] = rts_n;
		end
	endtask : sample
	initial begin
		#200000;
		err_count++;
		close_out();
	end
	initial begin
		{hsel, hwrite, jam, reset} = 4'h1;
		haddr = 32'h0;
		htrans = 2'h0;
		rx_pattern = 2'h0;
		hsize = 3'h2;
		hwdata = 32'h0;
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		foreach (rows[i]) begin
			bus(1'b1, rows[i].addr, rows[i].wdata);
			bus(1'b0, rows[i].addr, 32'h0);
			cmp(rd_val, rows[i].rdata);
		end
		// Reset in mid-run clears what the rows left behind
		reset <= 1'b1;
		repeat (4) @(posedge clk);
		cmp(32'({transmit_data_out_a, rts_n}), 32'h3);
		reset <= 1'b0;
		bus(1'b0, `BAUD_DIVISOR_OFS, 32'h0);
		cmp(rd_val, 32'h0);
		bus(1'b0, `CHANNEL_CONFIG_ONE_OFS, 32'h0);
		cmp(rd_val, 32'h0);
		// Bytes complete every 128 reference ticks, whatever the divisor
		bus(1'b1, `CHANNEL_CONFIG_ONE_OFS, 32'h2);
		for (int d = 0; d < 2; d++) begin
			bus(1'b1, `BAUD_DIVISOR_OFS, 32'(d));
			bus(1'b0, `RX_DATA_OFS, 32'h0);
			c0 = rd_val[15:8];
			// Two samples land exactly 512 clocks apart
			repeat (509) @(posedge clk);
			bus(1'b0, `RX_DATA_OFS, 32'h0);
			cmp(32'(rd_val[15:8] - c0), 32'h4 >> d);
		end
		bus(1'b1, `BAUD_DIVISOR_OFS, 32'h0);
		rx_pattern <= 2'h2;
		repeat (1200) @(posedge clk);
		bus(1'b0, `RX_DATA_OFS, 32'h0);
		cmp(32'(rd_val[7:0] == 8'h55 || rd_val[7:0] == 8'haa), 32'h1);
		// Under NRZI a change in every cell reads as all zeros
		bus(1'b1, `CHANNEL_CONFIG_ONE_OFS, 32'h12);
		repeat (1200) @(posedge clk);
		bus(1'b0, `RX_DATA_OFS, 32'h0);
		cmp(32'(rd_val[7:0]), 32'h0);
		// Bus mode, timing 01, request-to-send on frames
		bus(1'b1, `CHANNEL_CONFIG_ONE_OFS, 32'h128);
		bus(1'b1, `TX_DATA_OFS, 32'h1a4);
		fall();
		sample(1'b0);
		cmp(32'(bits), 32'ha4);
		cmp(32'(rts), 32'h01);
		// Priority drops at the drive edge after the last bit
		repeat (32) @(posedge clk);
		bus(1'b0, `LINE_STATUS_OFS, 32'h0);
		cmp(32'(rd_val[2]), 32'h1);
		// Low priority must wait past eight ones
		bus(1'b1, `TX_DATA_OFS, 32'h1a4);
		c0 = 8'h00;
		while (transmit_data_out_a !== 1'b0 && c0 < 8'h30) begin
			@(negedge tx_clock_pin);
			c0++;
		end
		cmp(32'(c0 >= 8'h08 && c0 < 8'h30), 32'h1);
		// Let this frame end before the next byte is queued
		repeat (320) @(posedge clk);
		// Another station pulls the bus low from the first bit
		bus(1'b1, `TX_DATA_OFS, 32'h1a4);
		fall();
		jam <= 1'b1;
		sample(1'b0);
		cmp(32'(bits[7:3]), 32'h1f);
		bus(1'b0, `LINE_STATUS_OFS, 32'h0);
		cmp(32'(rd_val[`ST_COLL_BIT]), 32'h1);
		jam <= 1'b0;
		bus(1'b1, `LINE_STATUS_OFS, 32'h10);
		bus(1'b0, `LINE_STATUS_OFS, 32'h0);
		cmp(32'(rd_val[`ST_COLL_BIT]), 32'h0);
		fall();
		sample(1'b0);
		cmp(32'(bits), 32'ha4);
		// Timing 11 drives on the falling edge
		bus(1'b1, `CHANNEL_CONFIG_ONE_OFS, 32'h168);
		bus(1'b1, `TX_DATA_OFS, 32'h1a4);
		fall();
		sample(1'b1);
		cmp(32'(bits), 32'ha4);
		// A held bus keeps the line at one
		jam <= 1'b1;
		bus(1'b1, `TX_DATA_OFS, 32'h1a4);
		c0 = 8'h00;
		repeat (640) begin
			@(posedge clk);
			if (transmit_data_out_a !== 1'b1)
				c0 = 8'h01;
		end
		cmp(32'(c0), 32'h0);
		close_out();
	end
endmodule : tb_hdlc_dpll_and_bus_access
